// ==== inc/iops_pkg.sv ====
// Constants shared by the I/O port with pin steering
`default_nettype none
package iops_pkg;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 5;
  localparam int          NUM_FN       = 5;
  // Register byte offsets
  localparam logic [4:0]  OFS_DIR      = 5'h00;
  localparam logic [4:0]  OFS_LEVEL    = 5'h04;
  localparam logic [4:0]  OFS_LATCH    = 5'h08;
  localparam logic [4:0]  OFS_ANALOG   = 5'h0c;
  localparam logic [4:0]  OFS_STEER    = 5'h10;
  // Reset values
  localparam logic [7:0]  DIR_RESET    = 8'hff;
  localparam logic [7:0]  LATCH_RESET  = 8'h00;
  localparam logic [7:0]  ANALOG_RESET = 8'hff;
  localparam logic [7:0]  STEER_RESET  = 8'h00;
  // Steering bit positions and masks
  localparam int          BIT_RX       = 7;
  localparam int          BIT_SDO      = 6;
  localparam int          BIT_SS       = 5;
  localparam int          BIT_TGATE    = 3;
  localparam int          BIT_TXCK     = 2;
  localparam logic [7:0]  STEER_MASK   = 8'hec;
  localparam logic [7:0]  LARGE_RO     = 8'h60;
  // Function indices on the peripheral ports
  localparam int          FN_RX        = 0;
  localparam int          FN_SDO       = 1;
  localparam int          FN_SS        = 2;
  localparam int          FN_TGATE     = 3;
  localparam int          FN_TXCK      = 4;
endpackage
`default_nettype wire

// ==== rtl/iops_port.sv ====
// GPIO port with direction, level, latch, analog select and pin steering
//
// Overview of operation
// [RULE_01] Port offers direction, pin-level and output-latch registers.
// [RULE_02] Pin owned by an enabled peripheral is never driven from the latch.
// [RULE_03] Peripheral-owned pins still read back through the pin-level path.
// [RULE_04] Writing latch register or pin-level register both update the latch.
// [RULE_05] Reading the latch register returns latch contents, not pin levels.
// [RULE_06] Reading the pin-level register returns the sampled pin levels.
// [RULE_07] Analog-select bit set disables that pin's digital input buffer.
// [RULE_08] Changing steering bits never alters direction register contents.
// [RULE_09] Steered function's drive and direction overrides go to selected pin.
// [RULE_10] Unselected candidate pin gets no override, acts as plain port pin.
// [RULE_11] Steering selects pins for rx, tx clock, serial out, select, gate.
// [RULE_12] Direction 1 makes pin input; 0 drives the latch onto the pin.
// [RULE_13] Analog pins always read 0 through the digital level path.
// [RULE_14] Steering bits reset to 0; unimplemented bits read 0, ignore writes.
// [RULE_15] Large package: serial out and select steering bits are read-only.
`timescale 1ns/100ps
`default_nettype none
module iops_port #(
  parameter int                            WIDTH     = 8,
  parameter bit                            LARGE_PKG = 1'b0,
  // Default and alternate pin index of each function, three bits each
  parameter logic [iops_pkg::NUM_FN*3-1:0] PIN_DEF   = 15'b000_001_010_011_100,
  parameter logic [iops_pkg::NUM_FN*3-1:0] PIN_ALT   = 15'b101_110_111_100_011
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [iops_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [iops_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                  byteenable,
  output var  logic [iops_pkg::DATA_W-1:0] readdata,
  output var  logic                        waitrequest,
  input  wire logic [WIDTH-1:0]            pin_in,
  output var  logic [WIDTH-1:0]            pin_out,
  output var  logic [WIDTH-1:0]            pin_oe,
  input  wire logic [iops_pkg::NUM_FN-1:0] fn_enable,
  input  wire logic [iops_pkg::NUM_FN-1:0] fn_out,
  input  wire logic [iops_pkg::NUM_FN-1:0] fn_drive,
  output var  logic [iops_pkg::NUM_FN-1:0] fn_in
);
  import iops_pkg::*;

  localparam int IW = 3;

  logic [WIDTH-1:0]   direction;
  logic [WIDTH-1:0]   latch;
  logic [WIDTH-1:0]   analog;
  logic [7:0]         steer;
  logic [WIDTH-1:0]   sample;
  logic [WIDTH-1:0]   next_direction;
  logic [WIDTH-1:0]   next_latch;
  logic [WIDTH-1:0]   next_analog;
  logic [7:0]         next_steer;
  logic [DATA_W-1:0]  next_readdata;
  logic               next_waitrequest;
  logic [WIDTH-1:0]   next_pin_out;
  logic [WIDTH-1:0]   next_pin_oe;
  logic [NUM_FN-1:0]  next_fn_in;
  logic [WIDTH-1:0]   gated_in;
  logic [NUM_FN-1:0]  fn_sel;
  logic [WIDTH-1:0]   ovr_hit;
  logic [WIDTH-1:0]   ovr_out;
  logic [WIDTH-1:0]   ovr_oe;
  logic               accept;
  logic               lane_ok;
  logic [7:0]         steer_wmask;

  // Every request pays one wait cycle, so readdata can come from a flop
  // Accept phase is the single cycle with waitrequest low
  assign accept      = (read | write) & ~waitrequest;
  assign lane_ok     = byteenable[0];
  assign steer_wmask = LARGE_PKG ? (STEER_MASK & ~LARGE_RO) : STEER_MASK; // [RULE_15]

  // Analog pins see no digital input at all
  assign gated_in = sample & ~analog; // [RULE_07] [RULE_13]

  assign fn_sel[FN_RX]    = steer[BIT_RX]; // [RULE_11]
  assign fn_sel[FN_SDO]   = steer[BIT_SDO];
  assign fn_sel[FN_SS]    = steer[BIT_SS];
  assign fn_sel[FN_TGATE] = steer[BIT_TGATE];
  assign fn_sel[FN_TXCK]  = steer[BIT_TXCK];

  // Per pin: lowest-numbered enabled function steered here wins
  genvar gp;
  generate
    for (gp = 0; gp < WIDTH; gp++) begin : g_pin
      always_comb begin
        logic [IW-1:0] target;
        target        = '0;
        ovr_hit[gp]   = 1'b0;
        ovr_out[gp]   = 1'b0;
        ovr_oe[gp]    = 1'b0;
        for (int f = NUM_FN - 1; f >= 0; f--) begin
          target = fn_sel[f] ? PIN_ALT[f*IW +: IW] : PIN_DEF[f*IW +: IW];
          if (fn_enable[f] && target == IW'(gp)) begin // [RULE_09] [RULE_10]
            ovr_hit[gp] = 1'b1;
            ovr_out[gp] = fn_out[f];
            ovr_oe[gp]  = fn_drive[f];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    next_pin_out = '0;
    next_pin_oe  = '0;
    next_fn_in   = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (ovr_hit[i]) begin
        next_pin_out[i] = ovr_out[i]; // [RULE_02]
        next_pin_oe[i]  = ovr_oe[i];
      end else begin
        next_pin_out[i] = latch[i];
        next_pin_oe[i]  = ~direction[i]; // [RULE_12]
      end
    end
    for (int f = 0; f < NUM_FN; f++) begin
      next_fn_in[f] = fn_sel[f] ? gated_in[PIN_ALT[f*IW +: IW]]
                                : gated_in[PIN_DEF[f*IW +: IW]];
    end
  end

  // Register file and bus slave
  always_comb begin
    next_direction   = direction;
    next_latch       = latch;
    next_analog      = analog;
    next_steer       = steer;
    next_readdata    = readdata;
    next_waitrequest = ~((read | write) & waitrequest);
    if (accept && write && lane_ok) begin
      unique case (address)
        OFS_DIR:    next_direction = writedata[WIDTH-1:0];
        OFS_LEVEL:  next_latch     = writedata[WIDTH-1:0]; // [RULE_04]
        OFS_LATCH:  next_latch     = writedata[WIDTH-1:0]; // [RULE_04]
        OFS_ANALOG: next_analog    = writedata[WIDTH-1:0];
        // Only direction-free steering state changes here
        OFS_STEER:  next_steer     = (steer & ~steer_wmask)
                                     | (writedata[7:0] & steer_wmask); // [RULE_08] [RULE_14]
        default:    next_steer     = steer;
      endcase
    end
    if ((read | write) && waitrequest) begin
      next_readdata = '0;
      if (read) begin
        unique case (address)
          OFS_DIR:    next_readdata = DATA_W'(direction); // [RULE_01]
          OFS_LEVEL:  next_readdata = DATA_W'(gated_in); // [RULE_03] [RULE_06]
          OFS_LATCH:  next_readdata = DATA_W'(latch); // [RULE_05]
          OFS_ANALOG: next_readdata = DATA_W'(analog);
          OFS_STEER:  next_readdata = DATA_W'(steer);
          default:    next_readdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      direction   <= DIR_RESET[WIDTH-1:0];
      latch       <= LATCH_RESET[WIDTH-1:0];
      analog      <= ANALOG_RESET[WIDTH-1:0];
      steer       <= STEER_RESET; // [RULE_14]
      sample      <= '0;
      readdata    <= '0;
      waitrequest <= 1'b1;
      pin_out     <= '0;
      pin_oe      <= '0;
      fn_in       <= '0;
    end else begin
      direction   <= next_direction;
      latch       <= next_latch;
      analog      <= next_analog;
      steer       <= next_steer;
      sample      <= pin_in;
      readdata    <= next_readdata;
      waitrequest <= next_waitrequest;
      pin_out     <= next_pin_out;
      pin_oe      <= next_pin_oe;
      fn_in       <= next_fn_in;
    end
  end

  // Checks
  sequence s_wr(logic [4:0] ofs);
    write && !waitrequest && lane_ok && address == ofs;
  endsequence

  sequence s_rd(logic [4:0] ofs);
    read && !waitrequest && address == ofs;
  endsequence

  property p_dir_read;
    @(posedge clk) disable iff (!reset_n)
      s_rd(OFS_DIR) |-> readdata == DATA_W'($past(direction));
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong"); // [RULE_01]

  property p_periph_owns;
    @(posedge clk) disable iff (!reset_n)
      ##1 1'b1 |-> ((pin_out ^ $past(ovr_out)) & $past(ovr_hit)) == '0
                && ((pin_oe ^ $past(ovr_oe)) & $past(ovr_hit)) == '0;
  endproperty
  a_periph_owns: assert property (p_periph_owns) // [RULE_02] [RULE_09]
    else $error("latch drove owned pin");

  property p_level_read;
    @(posedge clk) disable iff (!reset_n)
      s_rd(OFS_LEVEL) |-> readdata == DATA_W'($past(gated_in));
  endproperty
  a_level_read: assert property (p_level_read) // [RULE_03] [RULE_06]
    else $error("level read wrong");

  property p_level_write;
    @(posedge clk) disable iff (!reset_n)
      s_wr(OFS_LEVEL) |=> latch == $past(writedata[WIDTH-1:0]);
  endproperty
  a_level_write: assert property (p_level_write) // [RULE_04]
    else $error("level write missed latch");

  // Only an accepted write to the level or latch word may move the latch
  property p_latch_hold;
    @(posedge clk) disable iff (!reset_n)
      !(accept && write && lane_ok && (address == OFS_LEVEL || address == OFS_LATCH))
        |=> $stable(latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [RULE_04] [RULE_05]
    else $error("latch moved without write");

  property p_dir_write;
    @(posedge clk) disable iff (!reset_n)
      s_wr(OFS_DIR) |=> direction == $past(writedata[WIDTH-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) // [RULE_01]
    else $error("direction write lost");

  property p_latch_read;
    @(posedge clk) disable iff (!reset_n)
      s_rd(OFS_LATCH) |-> readdata == DATA_W'($past(latch));
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // [RULE_05]

  property p_analog_zero;
    @(posedge clk) disable iff (!reset_n)
      s_rd(OFS_LEVEL) |-> (readdata[WIDTH-1:0] & $past(analog)) == '0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) // [RULE_07] [RULE_13]
    else $error("analog pin read 1");

  property p_steer_keeps_dir;
    @(posedge clk) disable iff (!reset_n)
      s_wr(OFS_STEER) |=> $stable(direction);
  endproperty
  a_steer_keeps_dir: assert property (p_steer_keeps_dir) // [RULE_08]
    else $error("steer hit direction");

  property p_plain_pin;
    @(posedge clk) disable iff (!reset_n)
      ##1 1'b1 |-> ((pin_oe ^ ~$past(direction)) & ~$past(ovr_hit)) == '0
                && ((pin_out ^ $past(latch)) & ~$past(ovr_hit)) == '0;
  endproperty
  a_plain_pin: assert property (p_plain_pin) // [RULE_10] [RULE_12]
    else $error("plain pin overridden");

  property p_steer_bits;
    @(posedge clk) disable iff (!reset_n)
      (steer & ~STEER_MASK) == '0;
  endproperty
  a_steer_bits: assert property (p_steer_bits) // [RULE_11] [RULE_14]
    else $error("unimplemented steer bit");

  property p_large_ro;
    @(posedge clk) disable iff (!reset_n)
      LARGE_PKG |-> (steer & LARGE_RO) == '0;
  endproperty
  a_large_ro: assert property (p_large_ro) else $error("read-only steer bit set"); // [RULE_15]

  property p_one_cycle_ack;
    @(posedge clk) disable iff (!reset_n)
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_one_cycle_ack: assert property (p_one_cycle_ack) // [RULE_01]
    else $error("ack not one cycle");

  property p_steer_write;
    @(posedge clk) disable iff (!reset_n)
      s_wr(OFS_STEER) |=> steer == ($past(writedata[7:0]) & steer_wmask);
  endproperty
  a_steer_write: assert property (p_steer_write) // [RULE_14] [RULE_15]
    else $error("steer write not masked");

  // Writes with the low byte lane off are acknowledged but change nothing
  property p_be_off;
    @(posedge clk) disable iff (!reset_n)
      write && !waitrequest && !lane_ok
        |=> $stable(direction) && $stable(latch) && $stable(analog) && $stable(steer);
  endproperty
  a_be_off: assert property (p_be_off) // [RULE_01]
    else $error("disabled lane wrote");
endmodule
`default_nettype wire

// ==== dv/iops_pin_model.sv ====
// Pin-side partner: outside drivers meeting the port's own pin drivers
`timescale 1ns/100ps
`default_nettype none
module iops_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] ext_level,
  output var  logic [W-1:0] pin_in
);
  // Released pins follow the outside level, never the last driven value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule
`default_nettype wire

// ==== dv/iops_port_tb_top.sv ====
// Self-checking bench for the I/O port with pin steering
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module iops_port_tb_top;
  import iops_pkg::*;
  localparam logic [14:0] def_pins = 15'b000_001_010_011_100;
  localparam logic [14:0] alt_pins = 15'b101_110_111_100_011;
  localparam int          sel_bit[5] = '{BIT_RX, BIT_SDO, BIT_SS, BIT_TGATE, BIT_TXCK};
  logic        clk, reset_n, read, write, waitrequest;
  logic [4:0]  address, fn_enable, fn_out, fn_drive, fn_in, fi;
  logic [31:0] writedata, readdata, q, readdata_l, ql;
  logic [3:0]  byteenable;
  logic [7:0]  pin_in, pin_out, pin_oe, ext_v, dir_v, lat_v, ana_v, str_v, eo, ee, el;
  int          mismatches = 0;
  int          samples_checked = 0;
  iops_port #(.WIDTH(8), .LARGE_PKG(1'b0), .PIN_DEF(def_pins), .PIN_ALT(alt_pins)) uut (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .fn_enable(fn_enable), .fn_out(fn_out), .fn_drive(fn_drive), .fn_in(fn_in));
  iops_pin_model #(.W(8)) pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_v),
    .pin_in(pin_in));
  // Large-package variant shares the bus; only its readback is compared
  iops_port #(.WIDTH(8), .LARGE_PKG(1'b1), .PIN_DEF(def_pins), .PIN_ALT(alt_pins)) uut_large (
    .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata_l),
    .waitrequest(), .pin_in(pin_in), .pin_out(), .pin_oe(),
    .fn_enable(fn_enable), .fn_out(fn_out), .fn_drive(fn_drive), .fn_in());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata;
    ql = readdata_l;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hf);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    `CHK(nm, {24'h0, e}, q)
  endtask
  function automatic logic [2:0] fpin(int f);
    return str_v[sel_bit[f]] ? alt_pins[f*3+:3] : def_pins[f*3+:3];
  endfunction
  // Lower function index wins when two functions land on one pin
  function automatic void expect_pins();
    eo = lat_v;
    ee = ~dir_v;
    for (int f = NUM_FN - 1; f >= 0; f--) begin
      if (fn_enable[f]) begin
        eo[fpin(f)] = fn_out[f];
        ee[fpin(f)] = fn_drive[f];
      end
    end
    el = ((ee & eo) | (~ee & ext_v)) & ~ana_v;
    for (int f = 0; f < NUM_FN; f++) begin
      fi[f] = el[fpin(f)];
    end
  endfunction
  initial begin
    {read, write, address, writedata, byteenable, fn_enable, fn_out, fn_drive, ext_v} = '0;
    reset_n = 1'b0;
    q = $urandom(78);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd("dir_rst", OFS_DIR, DIR_RESET);
    rd("lat_rst", OFS_LATCH, LATCH_RESET);
    rd("ana_rst", OFS_ANALOG, ANALOG_RESET);
    rd("str_rst", OFS_STEER, STEER_RESET);
    wr(OFS_STEER, 8'hff);
    rd("str_mask", OFS_STEER, STEER_MASK);
    `CHK("str_large", {24'h0, STEER_MASK & ~LARGE_RO}, ql)
    rd("dir_kept", OFS_DIR, DIR_RESET);
    wr(5'h14, 8'h5a);
    rd("unmapped", 5'h14, 8'h00);
    bus(1'b1, OFS_DIR, 32'h0, 4'h0);
    rd("be_off", OFS_DIR, DIR_RESET);
    $display("corner test done");
    for (int t = 0; t < 40; t++) begin
      dir_v = 8'($urandom);
      lat_v = 8'($urandom);
      ana_v = (t < 4) ? 8'h00 : 8'($urandom);
      str_v = 8'($urandom);
      ext_v <= 8'($urandom);
      fn_enable <= 5'($urandom);
      fn_out <= 5'($urandom);
      fn_drive <= 5'($urandom);
      wr(OFS_DIR, dir_v);
      wr(t[0] ? OFS_LATCH : OFS_LEVEL, lat_v);
      wr(OFS_ANALOG, ana_v);
      wr(OFS_STEER, str_v);
      str_v = str_v & STEER_MASK;
      repeat (3) @(posedge clk);
      expect_pins();
      `CHK("pin_oe", ee, pin_oe)
      `CHK("pin_out", eo & ee, pin_out & ee)
      `CHK("fn_in", fi, fn_in)
      rd("dir", OFS_DIR, dir_v);
      rd("latch", OFS_LATCH, lat_v);
      rd("level", OFS_LEVEL, el);
      rd("steer", OFS_STEER, str_v);
      `CHK("steer_large", {24'h0, str_v & ~LARGE_RO}, ql)
      $display("random test %0d done", t);
    end
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
